//--- rrs_unit.sv
// rotate, round and saturate execution unit with an apb mode/status window
// assumes the decoder presents one command per cycle with the source operand
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
module rrs_unit (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      exec_valid,
  input  wire rrs_pkg::rrs_cmd_t         exec_cmd,
  input  wire logic [rrs_pkg::ACC_W-1:0] src_data,
  output rrs_pkg::rrs_wb_t               wb_out,
  output rrs_pkg::rrs_flags_t            flags_out,
  output logic                           rotate_out_bit,
  output logic                           exec_reject
);
  import rrs_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [3:0]  ctrl_reg;
  logic [3:0]  ctrl_next;
  rrs_flags_t  flags_reg;
  rrs_flags_t  flags_next;
  rrs_wb_t     wb_reg;
  rrs_wb_t     wb_next;
  logic        rob_reg;
  logic        rob_next;
  logic        reject_reg;
  logic        pready_reg;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic        pslverr_reg;

  wire wide_overflow_mode   = ctrl_reg[CTRL_WIDE_BIT];
  wire rounding_mode_select = ctrl_reg[CTRL_RNDSEL_BIT];
  wire data_saturation_mode = ctrl_reg[CTRL_DSAT_BIT];
  wire legacy_compat_mode   = ctrl_reg[CTRL_COMPAT_BIT];

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  wire is_rotl  = exec_cmd.op == OP_ROTL;
  wire is_rotr  = exec_cmd.op == OP_ROTR;
  wire is_round = exec_cmd.op == OP_ROUND;
  wire is_clamp = exec_cmd.op == OP_CLAMP;
  wire is_rot   = is_rotl || is_rotr;

  // rounding cannot sit under a single-instruction repeat
  wire round_refused = exec_valid && is_round && exec_cmd.in_repeat;
  wire exec_go       = exec_valid && (is_rot || is_round || is_clamp) && !round_refused;

  // ---------------------------------------------------------------
  // rotate datapath
  // ---------------------------------------------------------------
  // inserted bit is the flag value before this instruction executes
  wire bit_in = exec_cmd.in_sel_carry ? flags_reg.carry : flags_reg.tcb;

  wire [ACC_W-1:0] acc_opnd = exec_cmd.src_acc ? src_data :
                              {{(ACC_W-REG_W){1'b0}}, src_data[REG_W-1:0]};
  wire [REG_W-1:0] reg_opnd = src_data[REG_W-1:0];

  wire [ACC_W-1:0] rotl_acc = wide_overflow_mode ?
                              {acc_opnd[ACC_W-2:0], bit_in} :
                              {8'h00, acc_opnd[FRAME_MSB-1:0], bit_in};
  wire             rotl_acc_out = wide_overflow_mode ? acc_opnd[ACC_W-1] :
                                                       acc_opnd[FRAME_MSB];
  wire [ACC_W-1:0] rotr_acc = wide_overflow_mode ?
                              {bit_in, acc_opnd[ACC_W-1:1]} :
                              {8'h00, bit_in, acc_opnd[FRAME_MSB:1]};
  wire             rotr_acc_out = acc_opnd[0];
  wire [REG_W-1:0] rotl_reg = {reg_opnd[REG_W-2:0], bit_in};
  wire             rotl_reg_out = reg_opnd[REG_W-1];
  wire [REG_W-1:0] rotr_reg = {bit_in, reg_opnd[REG_W-1:1]};
  wire             rotr_reg_out = reg_opnd[0];

  wire [ACC_W-1:0] rot_acc_val = is_rotl ? rotl_acc : rotr_acc;
  wire [REG_W-1:0] rot_reg_val = is_rotl ? rotl_reg : rotr_reg;
  wire             rot_acc_out = is_rotl ? rotl_acc_out : rotr_acc_out;
  wire             rot_reg_out = is_rotl ? rotl_reg_out : rotr_reg_out;
  wire             rot_out     = exec_cmd.dst_acc ? rot_acc_out : rot_reg_out;
  wire [ACC_W-1:0] rot_val     = exec_cmd.dst_acc ? rot_acc_val :
                                 {{(ACC_W-REG_W){1'b0}}, rot_reg_val};

  // ---------------------------------------------------------------
  // rounding and clamping datapath
  // ---------------------------------------------------------------
  // clamp always checks the 32-bit frame; rounding follows the wide mode
  wire             rs_round = is_round || exec_cmd.rnd_req;
  wire             rs_wide  = is_round && wide_overflow_mode;
  wire             rs_clamp = is_clamp || data_saturation_mode;
  wire [ACC_W-1:0] rs_val;
  wire             rs_ovf;

  rrs_round_sat u_round_sat (
    .acc_in               (src_data),
    .do_round             (rs_round),
    .rounding_mode_select (rounding_mode_select),
    .legacy_compat_mode   (legacy_compat_mode),
    .wide_detect          (rs_wide),
    .clamp_en             (rs_clamp),
    .acc_out              (rs_val),
    .ovf                  (rs_ovf)
  );

  wire acov_event = exec_go && !is_rot && rs_ovf;
  wire [3:0] acov_set = acov_event ? (4'h1 << exec_cmd.dst_idx[1:0]) : 4'h0;

  // ---------------------------------------------------------------
  // apb slave: one wait state, answer registered
  // ---------------------------------------------------------------
  wire apb_acc    = psel && penable && !pready_reg;
  wire hit_ctrl   = paddr == CTRL_OFF;
  wire hit_stat   = paddr == STAT_OFF;
  wire hit_res_lo = paddr == RES_LO_OFF;
  wire hit_res_hi = paddr == RES_HI_OFF;
  wire hit_any    = hit_ctrl || hit_stat || hit_res_lo || hit_res_hi;
  wire wr_ctrl    = apb_acc && pwrite && hit_ctrl;
  wire wr_stat    = apb_acc && pwrite && hit_stat;

  wire [31:0] stat_word = {26'h0, flags_reg.acov, flags_reg.tcb, flags_reg.carry};

  assign prdata_next = !hit_any   ? 32'h0 :
                       hit_ctrl   ? {28'h0, ctrl_reg} :
                       hit_stat   ? stat_word :
                       hit_res_lo ? wb_reg.data[31:0] :
                                    {24'h0, wb_reg.data[ACC_W-1:GUARD_LSB]};

  assign ctrl_next = wr_ctrl ? pwdata[3:0] : ctrl_reg;

  // ---------------------------------------------------------------
  // flag update: the executing instruction wins over a software write
  // ---------------------------------------------------------------
  wire rot_to_carry = exec_go && is_rot && exec_cmd.out_sel_carry;
  wire rot_to_tcb   = exec_go && is_rot && !exec_cmd.out_sel_carry;
  wire sw_carry     = wr_stat ? pwdata[STAT_CARRY_BIT] : flags_reg.carry;
  wire sw_tcb       = wr_stat ? pwdata[STAT_TCB_BIT] : flags_reg.tcb;
  wire [3:0] sw_acov = wr_stat ? pwdata[STAT_ACOV_LSB +: 4] : flags_reg.acov;

  // rounding and clamping never reach carry; only a rotate or software does
  assign flags_next.carry = rot_to_carry ? rot_out : sw_carry;
  assign flags_next.tcb   = rot_to_tcb ? rot_out : sw_tcb;
  // a hardware set in the same cycle as a software clear survives
  assign flags_next.acov  = sw_acov | acov_set;

  assign rob_next = (exec_go && is_rot) ? rot_out : rob_reg;

  // ---------------------------------------------------------------
  // writeback: only the destination, in the same cycle as the flags
  // ---------------------------------------------------------------
  assign wb_next.vld     = exec_go;
  assign wb_next.dst_acc = exec_go ? (exec_cmd.dst_acc || !is_rot) : wb_reg.dst_acc;
  assign wb_next.dst_idx = exec_go ? exec_cmd.dst_idx : wb_reg.dst_idx;
  assign wb_next.data    = !exec_go ? wb_reg.data :
                           is_rot   ? rot_val : rs_val;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg        <= CTRL_RST;
      flags_reg.carry <= STAT_CARRY_RST;
      flags_reg.tcb   <= STAT_TCB_RST;
      flags_reg.acov  <= STAT_ACOV_RST;
      wb_reg          <= '0;
      rob_reg         <= 1'b0;
      reject_reg      <= 1'b0;
    end else begin
      ctrl_reg   <= ctrl_next;
      flags_reg  <= flags_next;
      wb_reg     <= wb_next;
      rob_reg    <= rob_next;
      reject_reg <= round_refused;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= apb_acc;
      prdata_reg  <= (apb_acc && !pwrite) ? prdata_next : 32'h0;
      pslverr_reg <= apb_acc && !hit_any;
    end
  end

  assign prdata         = prdata_reg;
  assign pready         = pready_reg;
  assign pslverr        = pslverr_reg;
  assign wb_out         = wb_reg;
  assign flags_out      = flags_reg;
  assign rotate_out_bit = rob_reg;
  assign exec_reject    = reject_reg;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  wire sel_flag_now = exec_cmd.out_sel_carry ? flags_reg.carry : flags_reg.tcb;
  logic out_sel_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_sel_q <= 1'b0;
    end else begin
      out_sel_q <= exec_cmd.out_sel_carry;
    end
  end
  wire sel_flag_q = out_sel_q ? flags_reg.carry : flags_reg.tcb;

  a_rotl_insert: assert property (@(posedge pclk) disable iff (!presetn)
    exec_go && is_rotl |=> wb_reg.data[0] == $past(bit_in))
    else $error("left rotate did not insert the old flag at bit 0");

  a_rotl_eject: assert property (@(posedge pclk) disable iff (!presetn)
    exec_go && is_rotl && exec_cmd.dst_acc && !wide_overflow_mode
    |=> sel_flag_q == $past(acc_opnd[FRAME_MSB]))
    else $error("narrow left rotate did not eject bit 31");

  a_guard_clear: assert property (@(posedge pclk) disable iff (!presetn)
    exec_go && is_rot && exec_cmd.dst_acc && !wide_overflow_mode
    |=> wb_reg.data[ACC_W-1:GUARD_LSB] == 8'h00)
    else $error("narrow accumulator rotate left guard bits set");

  a_zero_extend: assert property (@(posedge pclk) disable iff (!presetn)
    exec_go && is_rotl && exec_cmd.dst_acc && !exec_cmd.src_acc
    |=> wb_reg.data[ACC_W-1:REG_W+1] == '0)
    else $error("16-bit source was not zero extended");

  a_rotl_narrow: assert property (@(posedge pclk) disable iff (!presetn)
    exec_go && is_rotl && !exec_cmd.dst_acc
    |=> wb_reg.data[REG_W-1:1] == $past(src_data[REG_W-2:0])
        && sel_flag_q == $past(src_data[REG_W-1]))
    else $error("16-bit left rotate wrong");

  a_rotr_acc: assert property (@(posedge pclk) disable iff (!presetn)
    exec_go && is_rotr && exec_cmd.dst_acc
    |=> sel_flag_q == $past(acc_opnd[0]) && rotate_out_bit == sel_flag_q)
    else $error("accumulator right rotate did not eject bit 0");

  a_rotr_narrow: assert property (@(posedge pclk) disable iff (!presetn)
    exec_go && is_rotr && !exec_cmd.dst_acc
    |=> wb_reg.data[REG_W-1] == $past(bit_in) && wb_reg.data[ACC_W-1:REG_W] == '0)
    else $error("16-bit right rotate did not insert at bit 15");

  a_round_clear: assert property (@(posedge pclk) disable iff (!presetn)
    exec_go && is_round && !rounding_mode_select && !legacy_compat_mode
    && !data_saturation_mode |=> wb_reg.data[15:0] == 16'h0000)
    else $error("biased rounding left low bits");

  a_carry_kept: assert property (@(posedge pclk) disable iff (!presetn)
    exec_go && !is_rot && !wr_stat |=> $stable(flags_reg.carry))
    else $error("rounding or clamping changed carry");

  a_acov_set: assert property (@(posedge pclk) disable iff (!presetn)
    exec_go && !is_rot && rs_ovf |=> flags_reg.acov[$past(exec_cmd.dst_idx[1:0])])
    else $error("overflow flag of destination not set");

  a_clamp_frame: assert property (@(posedge pclk) disable iff (!presetn)
    exec_go && is_clamp |=> (&wb_reg.data[ACC_W-1:FRAME_MSB])
                            || !(|wb_reg.data[ACC_W-1:FRAME_MSB]))
    else $error("clamp result outside the 32-bit frame");

  a_repeat_round: assert property (@(posedge pclk) disable iff (!presetn)
    round_refused |=> exec_reject && !wb_reg.vld ##1 !exec_reject || $past(round_refused))
    else $error("repeated rounding was not refused");

  a_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    exec_go |=> wb_reg.vld && wb_reg.dst_idx == $past(exec_cmd.dst_idx))
    else $error("operation did not complete in one cycle");

  a_flag_sample: assert property (@(posedge pclk) disable iff (!presetn)
    exec_go && is_rot && exec_cmd.in_sel_carry == exec_cmd.out_sel_carry
    && sel_flag_now != rot_out |=> sel_flag_q != $past(sel_flag_now))
    else $error("rotate flag was not updated");

endmodule : rrs_unit
`default_nettype wire

//--- rrs_pkg.sv
// package for the rotate, round and saturate execution unit
// assumes a 40-bit accumulator datapath and 16-bit auxiliary/temporary registers
package rrs_pkg;

  localparam int ACC_W = 40;
  localparam int REG_W = 16;
  localparam int FRAME_MSB = 31;
  localparam int GUARD_LSB = 32;

  // apb register byte offsets
  localparam logic [11:0] CTRL_OFF   = 12'h000;
  localparam logic [11:0] STAT_OFF   = 12'h004;
  localparam logic [11:0] RES_LO_OFF = 12'h008;
  localparam logic [11:0] RES_HI_OFF = 12'h00c;

  // mode register fields
  localparam int CTRL_WIDE_BIT   = 0;
  localparam int CTRL_RNDSEL_BIT = 1;
  localparam int CTRL_DSAT_BIT   = 2;
  localparam int CTRL_COMPAT_BIT = 3;
  localparam logic [3:0] CTRL_RST = 4'h8;

  // status register fields
  localparam int STAT_CARRY_BIT = 0;
  localparam int STAT_TCB_BIT   = 1;
  localparam int STAT_ACOV_LSB  = 2;
  localparam logic STAT_CARRY_RST = 1'b1;
  localparam logic STAT_TCB_RST   = 1'b1;
  localparam logic [3:0] STAT_ACOV_RST = 4'h0;

  // rounding and saturation constants
  localparam logic [15:0]      RND_HALF  = 16'h8000;
  localparam logic [ACC_W-1:0] RND_CONST = 40'h00_0000_8000;
  localparam logic [ACC_W-1:0] SAT_POS32 = 40'h00_7fff_ffff;
  localparam logic [ACC_W-1:0] SAT_NEG32 = 40'hff_8000_0000;
  localparam logic [ACC_W-1:0] SAT_POS40 = 40'h7f_ffff_ffff;
  localparam logic [ACC_W-1:0] SAT_NEG40 = 40'h80_0000_0000;

  typedef enum logic [2:0] {
    OP_NONE  = 3'b000,
    OP_ROTL  = 3'b001,
    OP_ROTR  = 3'b011,
    OP_ROUND = 3'b010,
    OP_CLAMP = 3'b110
  } rrs_op_t;

  typedef struct packed {
    rrs_op_t    op;
    logic       in_sel_carry;
    logic       out_sel_carry;
    logic       src_acc;
    logic       dst_acc;
    logic [3:0] dst_idx;
    logic       rnd_req;
    logic       in_repeat;
  } rrs_cmd_t;

  typedef struct packed {
    logic             vld;
    logic             dst_acc;
    logic [3:0]       dst_idx;
    logic [ACC_W-1:0] data;
  } rrs_wb_t;

  typedef struct packed {
    logic       carry;
    logic       tcb;
    logic [3:0] acov;
  } rrs_flags_t;

endpackage : rrs_pkg

//--- rrs_round_sat.sv
// rounding adder with overflow detection and clamping, purely combinational
// assumes the caller registers the result and owns all status flags
`timescale 1ns/10ps
`default_nettype none
module rrs_round_sat (
  input  wire logic [rrs_pkg::ACC_W-1:0] acc_in,
  input  wire logic                      do_round,
  input  wire logic                      rounding_mode_select,
  input  wire logic                      legacy_compat_mode,
  input  wire logic                      wide_detect,
  input  wire logic                      clamp_en,
  output logic      [rrs_pkg::ACC_W-1:0] acc_out,
  output logic                           ovf
);
  import rrs_pkg::*;

  wire [15:0]      low_half = acc_in[15:0];
  wire             above    = low_half > RND_HALF;
  wire             tie_odd  = (low_half == RND_HALF) && acc_in[16];
  // unbiased mode adds only above half or on a tie with odd bit 16
  wire             rnd_add  = do_round && (!rounding_mode_select || above || tie_odd);
  wire [ACC_W-1:0] sum      = acc_in + (rnd_add ? RND_CONST : '0);
  // compat mode keeps the low half so old code sees the same bits
  wire [ACC_W-1:0] trimmed  = (rnd_add && !legacy_compat_mode) ?
                              {sum[ACC_W-1:16], 16'h0000} : sum;
  wire             fits32   = (&trimmed[ACC_W-1:FRAME_MSB]) || !(|trimmed[ACC_W-1:FRAME_MSB]);
  // 40-bit overflow can only come from a positive operand wrapping
  wire             ovf40    = rnd_add && !acc_in[ACC_W-1] && sum[ACC_W-1];
  wire             neg_dir  = wide_detect ? acc_in[ACC_W-1] : trimmed[ACC_W-1];
  wire [ACC_W-1:0] sat_val  = wide_detect ? (neg_dir ? SAT_NEG40 : SAT_POS40) :
                                            (neg_dir ? SAT_NEG32 : SAT_POS32);

  assign ovf     = wide_detect ? ovf40 : !fits32;
  assign acc_out = (ovf && clamp_en) ? sat_val : trimmed;

endmodule : rrs_round_sat
`default_nettype wire

//--- rrs_dec_model.sv
// decoder and register file stand-in: presents one command per request
// assumes the bench raises req for one cycle per command, off the sampling edge
`timescale 1ns/10ps
`default_nettype none
module rrs_dec_model (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      req,
  input  wire rrs_pkg::rrs_cmd_t         req_cmd,
  input  wire logic [rrs_pkg::ACC_W-1:0] req_data,
  output logic                           exec_valid,
  output rrs_pkg::rrs_cmd_t              exec_cmd,
  output logic      [rrs_pkg::ACC_W-1:0] src_data
);
  import rrs_pkg::*;
  // idle operand is inverted every idle cycle, so it alternates between the last one and its inverse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exec_valid <= 1'b0;
      exec_cmd   <= '0;
      src_data   <= '0;
    end else begin
      exec_valid <= req;
      exec_cmd   <= req ? req_cmd : '0;
      src_data   <= req ? req_data : ~src_data;
    end
  end
endmodule : rrs_dec_model
`default_nettype wire

//--- testbench.sv
// self-checking bench for the rotate, round and saturate unit
// assumes apb answers with one wait state and results one cycle after a command
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module testbench;
  import rrs_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, req = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, exec_valid, rotate_out_bit, exec_reject, er;
  rrs_cmd_t req_cmd = '0, exec_cmd;
  logic [ACC_W-1:0] req_data = '0, src_data;
  rrs_wb_t wb_out;
  rrs_flags_t flags_out;
  int error_cnt = 0, tests_run = 0, cyc = 0;
  rrs_unit rrs_unit_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .exec_valid(exec_valid), .exec_cmd(exec_cmd), .src_data(src_data),
    .wb_out(wb_out), .flags_out(flags_out), .rotate_out_bit(rotate_out_bit),
    .exec_reject(exec_reject));
  rrs_dec_model rrs_dec_model_inst (.pclk(pclk), .presetn(presetn), .req(req),
    .req_cmd(req_cmd), .req_data(req_data), .exec_valid(exec_valid),
    .exec_cmd(exec_cmd), .src_data(src_data));
  initial forever #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      test_done();
    end
  end
  task automatic test_done();
    if (error_cnt == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  // one full transfer; the request is held until pready is seen at an edge, for at most 20 edges
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  function automatic rrs_cmd_t mk(rrs_op_t op, logic ic, logic oc, logic sa, logic da,
                                  logic [3:0] ix, logic rn, logic rp);
    mk = '{op, ic, oc, sa, da, ix, rn, rp};
  endfunction : mk
  // returns just after the edge at which the writeback stands
  task automatic run(input rrs_cmd_t c, input logic [ACC_W-1:0] d);
    @(posedge pclk);
    req <= 1;
    req_cmd <= c;
    req_data <= d;
    @(posedge pclk);
    req <= 0;
    @(posedge pclk);
    #1;
  endtask : run
  task automatic t_reset();
    apb(0, CTRL_OFF, 0);
    `CHK("ctrl", 32'h8, rd)
    apb(0, STAT_OFF, 0);
    `CHK("stat", 32'h3, rd)
    apb(0, 12'h010, 0);
    `CHK("unmapped", 2'b10, {er, |rd})
  endtask : t_reset
  task automatic t_rot();
    apb(1, CTRL_OFF, 0);
    run(mk(OP_ROTL, 0, 1, 1, 1, 1, 0, 0), 40'h0f_e340_5678);
    `CHK("rotl", 40'h00_c680_acf1, wb_out.data)
    `CHK("rotl flg", 3'b111, {wb_out.vld, flags_out.carry, rotate_out_bit})
    run(mk(OP_ROTR, 0, 0, 1, 1, 1, 0, 1), 40'h5f_b000_1234);
    `CHK("rotr", 40'h00_d800_091a, wb_out.data)
    `CHK("rotr flg", 3'b100, {wb_out.vld, flags_out.tcb, rotate_out_bit})
    run(mk(OP_ROTL, 1, 0, 1, 0, 2, 0, 0), 40'hff_ffff_8001);
    `CHK("rotl16", 41'h0_0000_0003, {wb_out.dst_acc, wb_out.data})
    `CHK("rotl16 flag b", 1'b1, flags_out.tcb)
    run(mk(OP_ROTR, 1, 1, 1, 0, 2, 0, 0), 40'hff_ffff_8001);
    `CHK("rotr16", 40'h00_0000_c000, wb_out.data)
    run(mk(OP_ROTL, 1, 0, 0, 1, 0, 0, 0), 40'h12_0000_4001);
    `CHK("rotl ext", 40'h00_0000_8003, wb_out.data)
    apb(1, CTRL_OFF, 1);
    run(mk(OP_ROTL, 0, 1, 1, 1, 0, 0, 0), 40'h80_0000_0001);
    `CHK("rotl wide", 41'h100_0000_0002, {flags_out.carry, wb_out.data})
  endtask : t_rot
  task automatic t_round();
    apb(1, CTRL_OFF, 2);
    run(mk(OP_ROUND, 0, 0, 1, 1, 1, 0, 0), 40'hef_0ff0_8023);
    `CHK("rnd", 40'hef_0ff1_0000, wb_out.data)
    `CHK("rnd flg", 2'b11, {flags_out.acov[1], flags_out.carry})
    run(mk(OP_ROUND, 0, 0, 1, 1, 2, 0, 0), 40'h00_0000_8000);
    `CHK("rnd tie", 41'h0_0000_8000, {flags_out.acov[2], wb_out.data})
    apb(1, CTRL_OFF, 0);
    run(mk(OP_ROUND, 0, 0, 1, 1, 2, 0, 0), 40'h00_0001_8000);
    `CHK("rnd bias", 40'h00_0002_0000, wb_out.data)
    apb(1, CTRL_OFF, 8);
    run(mk(OP_ROUND, 0, 0, 1, 1, 2, 0, 0), 40'h00_0000_1234);
    `CHK("rnd compat", 40'h00_0000_9234, wb_out.data)
    apb(1, CTRL_OFF, 4);
    run(mk(OP_ROUND, 0, 0, 1, 1, 3, 0, 0), 40'h00_7fff_8000);
    `CHK("rnd sat", 41'h1_007f_ffff_ff, {flags_out.acov[3], wb_out.data})
    run(mk(OP_ROUND, 0, 0, 1, 1, 2, 0, 1), 40'h00_0000_0001);
    `CHK("rnd rep", 2'b01, {wb_out.vld, exec_reject})
  endtask : t_round
  task automatic t_clamp();
    apb(1, CTRL_OFF, 0);
    run(mk(OP_CLAMP, 0, 0, 1, 1, 0, 0, 0), 40'hef_0ff0_8023);
    `CHK("clamp", 41'h1_ff80_0000_00, {flags_out.acov[0], wb_out.data})
    run(mk(OP_CLAMP, 0, 0, 1, 1, 1, 1, 0), 40'h00_7fff_8000);
    `CHK("clamp rnd", 40'h00_7fff_ffff, wb_out.data)
    apb(0, STAT_OFF, 0);
    `CHK("stat end", 32'h2d, rd)
  endtask : t_clamp
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    t_reset();
    t_rot();
    t_round();
    t_clamp();
    test_done();
  end
endmodule : testbench
`default_nettype wire
